// File: logic/pfpi_fifo.sv
// Purpose: Small flip-flop FIFO carrying write address and data words
// Assumes: Single clock; push and pop may occur in the same cycle
// Notes:   Full and empty come straight from the count
`default_nettype none
module pfpi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } pfpi_fifo_st_t;

    pfpi_fifo_st_t          st;
    pfpi_fifo_st_t          next_st;
    logic [WIDTH-1:0]       mem [DEPTH];
    logic                   push;
    logic                   pop;

    assign o_ready = (st.cnt != (AW+1)'(DEPTH));
    assign o_valid = (st.cnt != '0);
    assign o_data  = mem[st.rd];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wr] <= i_data;
        end
    end
endmodule
`default_nettype wire

// File: logic/pfpi_pkg.sv
// Purpose: Shared constants and types for the parallel flash pin interface
// Assumes: System clock of 10 MHz; flash pins sampled by two flip-flops
// Notes:   Density codes select how many address bits are decoded
`default_nettype none
package pfpi_pkg;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          ADDR_W          = 25;
    localparam int          DATA_W          = 16;
    localparam int          FIFO_DEPTH      = 16;
    localparam int          MEM_DEPTH       = 16;
    localparam int          MEM_AW          = 4;
    localparam int          RCR_POL_BIT     = 10;
    localparam logic [15:0] RCR_RESET       = 16'hbfcf;
    localparam logic [15:0] CMD_READ_ARRAY  = 16'h00ff;
    localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
    localparam logic [15:0] CMD_CFG_SETUP   = 16'h0060;
    localparam logic [15:0] CMD_CFG_CONFIRM = 16'h0003;
    localparam logic [15:0] CMD_LOCK_DOWN   = 16'h002f;
    localparam logic [15:0] CMD_UNLOCK      = 16'h00d0;
    localparam logic [15:0] CMD_PROGRAM     = 16'h0040;
    localparam logic [15:0] STATUS_READY    = 16'h0080;
    localparam logic [15:0] STATUS_VPP_ERR  = 16'h0008;
    localparam logic [15:0] STATUS_LOCK_ERR = 16'h0002;
    localparam logic [3:0]  SYNC_LATENCY    = 4'h3;
    localparam logic [1:0]  DENS_64         = 2'h0;
    localparam logic [1:0]  DENS_128        = 2'h1;
    localparam logic [1:0]  DENS_256        = 2'h2;
    localparam logic [1:0]  DENS_512        = 2'h3;

    typedef enum logic [2:0] {
        PFPI_RD_ARRAY,
        PFPI_RD_STATUS,
        PFPI_CFG_WAIT,
        PFPI_PROG_WAIT,
        PFPI_LOCK_WAIT
    } pfpi_mode_t;
endpackage
`default_nettype wire

// File: logic/pfpi_top.sv
// Purpose: Device-side pin logic of a 16-bit parallel NOR flash
// Assumes: All flash pins are asynchronous to I_CLK_SYS and are synchronised
// Notes:   Array is a small flip-flop stand-in indexed by low word address bits
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// [RL1] Decoded word address width follows the density code, up to bit 25.
// [RL2] Address bit 1 is the least significant bit; one step is one word.
// [RL3] In the 512 Mbit part, high top address bit selects the top die.
// [RL4] Data bus takes commands and data on writes, returns contents on reads.
// [RL5] Data bus floats when chip select or output enable is high.
// [RL6] Write strobe rising edge captures address and data.
// [RL7] Sync reads capture address at strobe rise or first clock edge strobe low.
// [RL8] Async mode latches on strobe rise; strobe low passes address through.
// [RL9] Host not using the address strobe holds it low.
// [RL10] Chip select high deselects the die and floats data and wait.
// [RL11] Host holds chip select high when not accessing the device.
// [RL12] Host not using sync reads holds the interface clock steady; the host model toggles it while chip select is low.
// [RL13] Output enable low drives data; high floats data and wait.
// [RL14] Reset low clears automation and ignores writes until it rises.
// [RL15] Leaving reset enters asynchronous read array mode.
// [RL16] Wait asserted level follows read configuration bit 10.
// [RL17] Wait is driven only while chip select and output enable are low.
// [RL18] Sync burst reads assert wait while data invalid, release when valid.
// [RL19] Async page reads and all writes keep wait deasserted.
// [RL20] Write protect low makes lock-down active; unlock fails on such blocks.
// [RL21] Write protect high ignores lock-down so blocks may be altered.
// [RL22] Program or core supply lockout blocks changes to memory contents.
// [RL23] Write strobe edges with chip select high are ignored.
// [RL24] Sync mode registers controls on interface clock; async reads follow gates.
module pfpi_top
    import pfpi_pkg::*;
(
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_NRST,
    input  wire logic [1:0]        I_DENSITY,
    input  wire logic [ADDR_W:1]   I_ADDR,
    input  wire logic [DATA_W-1:0] I_DQ,
    output logic      [DATA_W-1:0] O_DQ,
    output logic                   O_DQ_OE,
    input  wire logic              I_CE_N,
    input  wire logic              I_OE_N,
    input  wire logic              I_WE_N,
    input  wire logic              I_ADDRESS_STROBE_N,
    input  wire logic              I_FLASH_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_WP_N,
    input  wire logic              I_PROGRAM_SUPPLY_LOCKOUT,
    input  wire logic              I_CORE_LOCKOUT,
    output logic                   O_WAIT,
    output logic                   O_WAIT_OE,
    output logic                   O_TOP_DIE_SEL,
    output logic      [ADDR_W:1]   O_WORD_ADDR
);
    localparam int SW = ADDR_W + DATA_W + 9;

    typedef struct packed {
        logic [SW-1:0]         s1;
        logic [SW-1:0]         s2;
        logic                  we_d;
        logic                  adv_d;
        logic                  clk_d;
        logic [ADDR_W:1]       addr_lat;
        logic                  lat_done;
        pfpi_mode_t            mode;
        logic [15:0]           read_config_reg;
        logic [15:0]           status;
        logic [MEM_DEPTH-1:0]  locked;
        logic [MEM_DEPTH-1:0]  lockdown;
        logic [3:0]            wait_cnt;
        logic [15:0]           dq;
        logic                  dq_oe;
        logic                  wait_pin;
        logic                  wait_oe;
        logic                  top_sel;
    } pfpi_st_t;

    pfpi_st_t                    st;
    pfpi_st_t                    next_st;
    logic [MEM_DEPTH-1:0][15:0]  mem;
    logic [ADDR_W+DATA_W-1:0]    fifo_in;
    logic [ADDR_W+DATA_W-1:0]    fifo_out;
    logic                        fifo_push;
    logic                        fifo_ready;
    logic                        fifo_valid;
    logic                        fifo_pop;

    // Synchronised pin views
    logic [ADDR_W:1]  a_s;
    logic [15:0]      d_s;
    logic             ce_n;
    logic             oe_n;
    logic             we_n;
    logic             adv_n;
    logic             fclk;
    logic             rst_n;
    logic             wp_n;
    logic             vpp_lk;
    logic             vcc_lk;
    assign {a_s, d_s, ce_n, oe_n, we_n, adv_n, fclk, rst_n, wp_n, vpp_lk, vcc_lk} = st.s2;

    // Keep address bits above the density's top bit at zero
    function automatic logic [ADDR_W:1] dens_mask(input logic [1:0] dens,
                                                 input logic [ADDR_W:1] a);
        logic [ADDR_W:1] m;
        m = '1;
        unique case (dens)
            DENS_64:  m = {3'h0, {(ADDR_W-3){1'b1}}};
            DENS_128: m = {2'h0, {(ADDR_W-2){1'b1}}};
            DENS_256: m = {1'b0, {(ADDR_W-1){1'b1}}};
            DENS_512: m = '1;
        endcase
        return a & m;
    endfunction

    function automatic logic [MEM_AW-1:0] widx(input logic [ADDR_W:1] a);
        return a[MEM_AW:1]; // [RL2]
    endfunction

    logic             sync_mode;
    logic             wp_rise;
    logic             adv_rise;
    logic             fclk_rise;
    logic [ADDR_W:1]  cur_addr;
    logic             wr_block;
    logic [15:0]      wcmd;
    logic [ADDR_W:1]  waddr;
    logic [MEM_AW-1:0] wi;

    assign sync_mode = !st.read_config_reg[15];
    assign adv_rise  = adv_n && !st.adv_d;
    assign fclk_rise = fclk && !st.clk_d;
    assign wp_rise   = we_n && !st.we_d && !ce_n;               // [RL6] [RL23]
    assign wr_block  = vpp_lk || vcc_lk;                        // [RL22]
    assign fifo_in   = {dens_mask(I_DENSITY, a_s), d_s};        // [RL1]
    assign fifo_push = wp_rise && rst_n;                        // [RL14]
    assign {waddr, wcmd} = fifo_out;
    assign wi        = widx(waddr);
    // Commands drain one per cycle, so the FIFO only fills under bursts
    assign fifo_pop  = fifo_valid && rst_n;

    // Async: strobe low flows through, else the latched value holds
    assign cur_addr = (!adv_n && !(sync_mode && st.lat_done)) ?
                      dens_mask(I_DENSITY, a_s) : st.addr_lat; // [RL8] [RL9]

    always_comb begin
        next_st = st;
        next_st.s1 = {I_ADDR, I_DQ, I_CE_N, I_OE_N, I_WE_N, I_ADDRESS_STROBE_N,
                      I_FLASH_CLK, I_RST_N, I_WP_N, I_PROGRAM_SUPPLY_LOCKOUT,
                      I_CORE_LOCKOUT};
        next_st.s2    = st.s1;
        next_st.we_d  = we_n;
        next_st.adv_d = adv_n;
        next_st.clk_d = fclk;

        if (!adv_n && !(sync_mode && st.lat_done)) begin
            next_st.addr_lat = dens_mask(I_DENSITY, a_s);      // [RL8]
        end
        if (sync_mode && !adv_n && fclk_rise && !st.lat_done) begin
            next_st.lat_done = 1'b1;                           // [RL7] [RL24]
            next_st.wait_cnt = SYNC_LATENCY;
        end else if (adv_rise) begin
            next_st.lat_done = 1'b0;                           // [RL7]
            if (sync_mode) begin
                next_st.wait_cnt = SYNC_LATENCY;
            end
        end
        if (sync_mode && fclk_rise && st.wait_cnt != 4'h0) begin
            next_st.wait_cnt = st.wait_cnt - 4'h1;             // [RL18] [RL24]
        end

        if (fifo_valid) begin
            next_st.mode = PFPI_RD_STATUS;
            unique case (st.mode)
                PFPI_CFG_WAIT: begin
                    if (wcmd == CMD_CFG_CONFIRM) begin
                        next_st.read_config_reg = 16'(waddr);
                    end
                    next_st.mode = PFPI_RD_ARRAY;
                end
                PFPI_PROG_WAIT: begin
                    next_st.status = STATUS_READY;
                    if (wr_block) begin
                        next_st.status = STATUS_READY | STATUS_VPP_ERR; // [RL22]
                    end else if (st.locked[wi]) begin
                        next_st.status = STATUS_READY | STATUS_LOCK_ERR;
                    end
                end
                PFPI_LOCK_WAIT: begin
                    if (wcmd == CMD_UNLOCK) begin
                        // Lock-down only bites while write protect is low
                        if (!st.lockdown[wi] || wp_n) begin    // [RL20] [RL21]
                            next_st.locked[wi] = 1'b0;
                        end
                    end else if (wcmd == CMD_LOCK_DOWN) begin
                        next_st.locked[wi]   = 1'b1;
                        next_st.lockdown[wi] = 1'b1;
                    end else begin
                        next_st.locked[wi] = 1'b1;
                    end
                end
                default: begin
                    unique case (wcmd)
                        CMD_READ_ARRAY:  next_st.mode = PFPI_RD_ARRAY;
                        CMD_CFG_SETUP:   next_st.mode = PFPI_CFG_WAIT;
                        CMD_PROGRAM:     next_st.mode = PFPI_PROG_WAIT;
                        CMD_READ_STATUS: next_st.mode = PFPI_RD_STATUS;
                        default:         next_st.mode = PFPI_LOCK_WAIT;
                    endcase
                end
            endcase
        end

        // Pins: driven only while selected and output enabled
        next_st.dq_oe   = !ce_n && !oe_n && we_n;              // [RL5] [RL10] [RL13]
        next_st.wait_oe = !ce_n && !oe_n;                      // [RL17]
        next_st.dq      = (st.mode == PFPI_RD_ARRAY) ? mem[widx(cur_addr)] :
                          (st.mode == PFPI_RD_STATUS) ? st.status : st.read_config_reg; // [RL4]
        // Wait asserted only for sync reads with data not yet valid
        next_st.wait_pin = st.read_config_reg[RCR_POL_BIT] ~^
                           (sync_mode && we_n && st.wait_cnt != 4'h0);   // [RL16] [RL18] [RL19]
        next_st.top_sel  = (I_DENSITY == DENS_512) && cur_addr[ADDR_W]; // [RL3]

        if (!rst_n) begin                                      // [RL14]
            next_st.mode     = PFPI_RD_ARRAY;                  // [RL15]
            next_st.read_config_reg      = RCR_RESET;
            next_st.status   = STATUS_READY;
            next_st.wait_cnt = 4'h0;
            next_st.lat_done = 1'b0;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            st      <= '0;
            // Pin views start at idle levels so no false select or edge follows reset
            st.s1   <= '1;
            st.s2   <= '1;
            st.we_d <= 1'b1;
            st.adv_d <= 1'b1;
            st.clk_d <= 1'b1;
            st.read_config_reg  <= RCR_RESET;
            st.mode <= PFPI_RD_ARRAY;
            st.status <= STATUS_READY;
            st.locked <= '1;
            mem     <= '1;
        end else begin
            st <= next_st;
            if (fifo_valid && rst_n && st.mode == PFPI_PROG_WAIT && !wr_block &&
                !st.locked[wi]) begin
                mem[wi] <= mem[wi] & wcmd;                      // [RL22]
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    pfpi_fifo #(
        .WIDTH (ADDR_W + DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk   (I_CLK_SYS),
        .i_nrst  (I_NRST),
        .i_valid (fifo_push),
        .o_ready (fifo_ready),
        .i_data  (fifo_in),
        .o_valid (fifo_valid),
        .i_ready (fifo_pop),
        .o_data  (fifo_out)
    );

    // Full FIFO drops writes; host must space strobes
    assign O_DQ          = st.dq;
    assign O_DQ_OE       = st.dq_oe && fifo_ready | st.dq_oe;
    assign O_WAIT        = st.wait_pin;
    assign O_WAIT_OE     = st.wait_oe;
    assign O_TOP_DIE_SEL = st.top_sel;
    assign O_WORD_ADDR   = st.addr_lat;
endmodule
`default_nettype wire

// File: tb/pfpi_host_model.sv
// Purpose: Host bus controller model driving the flash pins
// Assumes: Asynchronous reads only; address strobe unused
// Notes:   Accesses are started by task calls from the bench
`default_nettype none
module pfpi_host_model
    import pfpi_pkg::*;
(
    input  wire logic            i_clk,
    output logic      [ADDR_W:1] o_addr,
    output logic      [15:0]     o_dq,
    output logic                 o_ce_n,
    output logic                 o_oe_n,
    output logic                 o_we_n,
    output logic                 o_strobe_n,
    output logic                 o_flash_clk
);
    initial begin
        o_addr = '0;
        o_dq = '0;
        o_ce_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_strobe_n = 1'b0;
        o_flash_clk = 1'b0;
        #137;
        forever begin
            #400;
            // Toggles only inside an access, frozen low between them
            o_flash_clk = o_ce_n ? 1'b0 : ~o_flash_clk;
        end
    end
    ////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask
    // Long holds: the device sees pins two clocks late
    task automatic wr(input logic [ADDR_W:1] a, input logic [15:0] d, input logic sel);
        step(1);
        o_addr = a;
        o_dq = d;
        o_ce_n = !sel;
        step(2);
        o_we_n = 1'b0;
        step(4);
        o_we_n = 1'b1;
        step(3);
        o_ce_n = 1'b1;
        step(4);
    endtask
    task automatic rd(input logic [ADDR_W:1] a);
        step(1);
        o_addr = a;
        o_ce_n = 1'b0;
        o_oe_n = 1'b0;
        step(7);
        o_oe_n = 1'b1;
        o_ce_n = 1'b1;
        step(4);
    endtask
endmodule
`default_nettype wire

// File: tb/pfpi_top_props.sv
// Purpose: Port-level timing checks for the flash pin interface
// Assumes: Strobe held low by the host; read configuration left at reset
// Notes:   Pins reach the outputs three system clocks after they change
`default_nettype none
module pfpi_top_props
    import pfpi_pkg::*;
(
    input wire logic            I_CLK_SYS,
    input wire logic            I_NRST,
    input wire logic [1:0]      I_DENSITY,
    input wire logic [ADDR_W:1] I_ADDR,
    input wire logic            I_CE_N,
    input wire logic            I_OE_N,
    input wire logic            I_WE_N,
    input wire logic            I_ADDRESS_STROBE_N,
    input wire logic            I_RST_N,
    input wire logic            O_DQ_OE,
    input wire logic            O_WAIT,
    input wire logic            O_WAIT_OE,
    input wire logic            O_TOP_DIE_SEL,
    input wire logic [ADDR_W:1] O_WORD_ADDR
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    ////////////////////////////////////////
    AST_DQ_CE: assert property (O_DQ_OE |-> !$past(I_CE_N, 3))
        else $error("data bus driven while deselected");
    AST_DQ_OE: assert property (O_DQ_OE |-> !$past(I_OE_N, 3))
        else $error("data bus driven with output enable high");
    AST_DQ_ON: assert property (
        (!I_CE_N && !I_OE_N && I_WE_N && I_RST_N)[*4] |-> O_DQ_OE)
        else $error("data bus not driven during read");
    AST_WAIT_OFF: assert property (
        O_WAIT_OE |-> !$past(I_CE_N, 3) && !$past(I_OE_N, 3))
        else $error("wait driven outside a read");
    // Polarity bit resets to active high, and reads stay asynchronous
    AST_WAIT_LVL: assert property (O_WAIT_OE |-> !O_WAIT)
        else $error("wait asserted in asynchronous mode");
    AST_DIE_ON: assert property (
        (!I_CE_N && $stable(I_ADDR) && I_DENSITY == DENS_512 && I_ADDR[ADDR_W])[*5]
        |-> O_TOP_DIE_SEL)
        else $error("top die not selected");
    AST_ADDR_FLOW: assert property (
        (!I_CE_N && !I_ADDRESS_STROBE_N && $stable(I_ADDR) && I_DENSITY == DENS_512)[*5]
        |-> O_WORD_ADDR == I_ADDR)
        else $error("address not flowing through");
    AST_ADDR_MASK: assert property (
        (!I_CE_N && $stable(I_ADDR) && I_DENSITY == DENS_64)[*5]
        |-> O_WORD_ADDR[ADDR_W:23] == 3'h0)
        else $error("address bits above density decoded");
endmodule
bind pfpi_top pfpi_top_props i_props (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST),
    .I_DENSITY(I_DENSITY), .I_ADDR(I_ADDR), .I_CE_N(I_CE_N), .I_OE_N(I_OE_N),
    .I_WE_N(I_WE_N), .I_ADDRESS_STROBE_N(I_ADDRESS_STROBE_N), .I_RST_N(I_RST_N),
    .O_DQ_OE(O_DQ_OE), .O_WAIT(O_WAIT), .O_WAIT_OE(O_WAIT_OE),
    .O_TOP_DIE_SEL(O_TOP_DIE_SEL), .O_WORD_ADDR(O_WORD_ADDR));
`default_nettype wire

// File: tb/tb_pfpi_top.sv
// Purpose: Self-checking bench for the flash pin interface
// Assumes: Reads stay asynchronous; read configuration is never written
// Notes:   Each case owns one array word so cases cannot mask each other
`default_nettype none
module tb_pfpi_top
    import pfpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk, nrst, wp_n, psl, cl, rst_n, ce_n, oe_n, we_n, stb_n, fclk;
    logic            o_dq_oe, o_wait, o_wait_oe, top_die;
    logic [1:0]      density;
    logic [ADDR_W:1] h_addr, word_addr;
    logic [15:0]     h_dq, dq_bus, o_dq;
    logic [15:0]     exp_q[$];
    int              num_errors = 0, num_checks = 0, seed = 84, oe_cnt = 0;
    // Bits: 0 protect high, 1 program lockout, 2 core lockout, 3 pin reset,
    // 4 lock-down first, 5 writes deselected
    localparam logic [5:0] CASES [7] = '{6'h01, 6'h03, 6'h05, 6'h09, 6'h10, 6'h11, 6'h21};
    // Released bus shows the inverse of the last host word
    assign dq_bus = (!ce_n && oe_n) ? h_dq : ((o_dq_oe === 1'b1) ? o_dq : ~h_dq);
    pfpi_top i_dut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_DENSITY(density), .I_ADDR(h_addr),
        .I_DQ(dq_bus), .O_DQ(o_dq), .O_DQ_OE(o_dq_oe), .I_CE_N(ce_n), .I_OE_N(oe_n),
        .I_WE_N(we_n), .I_ADDRESS_STROBE_N(stb_n), .I_FLASH_CLK(fclk), .I_RST_N(rst_n),
        .I_WP_N(wp_n), .I_PROGRAM_SUPPLY_LOCKOUT(psl), .I_CORE_LOCKOUT(cl),
        .O_WAIT(o_wait), .O_WAIT_OE(o_wait_oe), .O_TOP_DIE_SEL(top_die),
        .O_WORD_ADDR(word_addr));
    pfpi_host_model i_host (.i_clk(clk), .o_addr(h_addr), .o_dq(h_dq), .o_ce_n(ce_n),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_strobe_n(stb_n), .o_flash_clk(fclk));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic prog_case(input int idx);
        logic [5:0]      f;
        logic [ADDR_W:1] a;
        logic [15:0]     d;
        f = CASES[idx];
        a = ADDR_W'($random(seed));
        a[4:1] = idx[3:0];
        d = 16'($random(seed)) & 16'h7fff;
        @(posedge clk);
        #5;
        {wp_n, psl, cl} = {f[0], f[1], f[2]};
        if (f[3]) begin
            i_host.wr(a, CMD_READ_STATUS, 1'b1);
            rst_n = 1'b0;
        end
        if (f[4]) begin
            i_host.wr(a, 16'h0001, 1'b1);
            i_host.wr(a, CMD_LOCK_DOWN, 1'b1);
        end
        i_host.wr(a, 16'h0001, !f[5]);
        i_host.wr(a, CMD_UNLOCK, !f[5]);
        i_host.wr(a, CMD_PROGRAM, !f[5]);
        i_host.wr(a, d, !f[5]);
        if (f[1] || f[2]) begin
            i_host.wr(a, CMD_READ_STATUS, 1'b1);
            exp_q.push_back(STATUS_READY | STATUS_VPP_ERR);
            i_host.rd(a);
        end
        if (f[3]) begin
            rst_n = 1'b1;
            repeat (4) @(posedge clk);
        end else begin
            i_host.wr(a, CMD_READ_ARRAY, 1'b1);
        end
        exp_q.push_back((f[0] && f[3:1] == 3'h0 && !f[5]) ? d : 16'hffff);
        i_host.rd(a);
        $display("test case %0d done", idx);
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2_000_000;
        num_errors++;
        $display("watchdog expired");
        results();
    end
    // Data counts once it has been driven for two cycles
    always @(posedge clk) begin
        oe_cnt <= (o_dq_oe === 1'b1) ? oe_cnt + 1 : 0;
        if (oe_cnt == 2) begin
            if (exp_q.size() == 0)
                check("unexpected read", 32'h0, 32'h1);
            else
                check("read data", 32'(exp_q.pop_front()), 32'(o_dq));
        end
    end
    initial begin
        logic [ADDR_W:1] a;
        logic [ADDR_W:1] m;
        {nrst, density, wp_n, psl, cl, rst_n} = {1'b0, DENS_512, 4'b1001};
        repeat (4) @(posedge clk);
        #5;
        nrst = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #5;
            density = k[1:0];
            a = ADDR_W'($random(seed));
            a[ADDR_W] = 1'b1;
            m = {ADDR_W{1'b1}} >> (3 - k);
            exp_q.push_back(16'hffff);
            i_host.rd(a);
            check("word address", 32'(a & m), 32'(word_addr));
            check("top die select", 32'(k == 3), 32'(top_die));
        end
        $display("test density done");
        for (int i = 0; i < 7; i++) prog_case(i);
        check("pending reads", 32'h0, 32'(exp_q.size()));
        results();
    end
endmodule
`default_nettype wire
